// ===== design/can_acceptance_filter_steering.sv
`timescale 1ns/1ps
`include "can_filter_map.svh"
module can_acceptance_filter_steering
  import can_filter_pkg::*;
#(
  parameter int NUM_FILTERS = 16,
  parameter int NUM_MASKS   = 3
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // APB slave
  input  wire logic [7:0]              paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Received message from the protocol engine
  input  wire logic                    msgValid,
  input  wire can_filter_pkg::std_id_t msgSid,
  input  wire can_filter_pkg::ext_id_t msgEid,
  input  wire logic                    msgExt,
  // Steering result
  output logic                         acceptValid,
  output logic                         acceptFifo,
  output can_filter_pkg::target_ptr_t  acceptBuffer,
  output logic [3:0]                   acceptFilter,
  output can_filter_pkg::reg16_t       rxSlotFullFlag
);
  import can_filter_pkg::*;

  // ****************************************************************
  // Register storage
  // ****************************************************************
  reg16_t       filterAcceptEnable;
  target_ptr_t  filterTargetPointer [NUM_FILTERS];
  mask_choice_t filterMaskChoice    [NUM_FILTERS];
  std_id_t      filtSid             [NUM_FILTERS];
  ext_id_t      filtEid             [NUM_FILTERS];
  logic         filterFrameTypeSelect [NUM_FILTERS];
  std_id_t      maskSid             [NUM_MASKS];
  ext_id_t      maskEid             [NUM_MASKS];
  logic         maskFrameTypeEnforce [NUM_MASKS];
  logic [3:0]   lastFilter;
  target_ptr_t  lastPointer;
  logic         lastFifo;
  logic         hitSeen;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic       wrEn;
  logic       rdEn;
  logic       inFilter;
  logic       inMask;
  logic [3:0] filtIdx;
  logic [1:0] maskIdx;
  logic       eidHalf;
  logic       mapped;

  assign wrEn     = psel & penable & pwrite;
  assign rdEn     = psel & penable & ~pwrite;
  assign inFilter = (paddr >= `OFF_FILTER_BASE) && (paddr <= `OFF_FILTER_LAST);
  assign inMask   = (paddr >= `OFF_MASK_BASE) && (paddr <= `OFF_MASK_LAST);
  // Filters and masks each take eight bytes, counted from their own base.
  // Subtracting the base keeps filter 0 at index 0.
  assign filtIdx  = 4'((paddr - `OFF_FILTER_BASE) >> 3);
  assign maskIdx  = 2'((paddr - `OFF_MASK_BASE) >> 3);
  assign eidHalf  = paddr[2];
  assign pready   = 1'b1;

  always_comb begin
    case (paddr)
      `OFF_FILTER_ENABLE, `OFF_BUFPNT_0_3, `OFF_BUFPNT_4_7, `OFF_BUFPNT_8_11,
      `OFF_BUFPNT_12_15, `OFF_MASKSEL_0_7, `OFF_MASKSEL_8_15, `OFF_RX_FULL,
      `OFF_HIT_STATUS: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = inFilter | inMask;
      end
    endcase
  end

  // Unmapped addresses answer with an error and read as zero.
  assign pslverr = psel & penable & ~mapped;

  // ****************************************************************
  // Filter enable
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      filterAcceptEnable <= `RST_FILTER_ENABLE;
    end else if (wrEn && paddr == `OFF_FILTER_ENABLE) begin
      filterAcceptEnable <= pwdata[15:0];
    end
  end

  // ****************************************************************
  // Buffer pointers and mask selection
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_FILTERS; i++) begin
        filterTargetPointer[i] <= 4'h0;
      end
    end else if (wrEn) begin
      for (int i = 0; i < NUM_FILTERS; i++) begin
        if (paddr == 8'(`OFF_BUFPNT_0_3 + 4 * (i / 4))) begin
          filterTargetPointer[i] <= pwdata[4 * (i % 4) +: 4];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_FILTERS; i++) begin
        filterMaskChoice[i] <= 2'b00;
      end
    end else if (wrEn) begin
      for (int i = 0; i < NUM_FILTERS; i++) begin
        if (paddr == 8'(`OFF_MASKSEL_0_7 + 4 * (i / 8))) begin
          filterMaskChoice[i] <= pwdata[2 * (i % 8) +: 2];
        end
      end
    end
  end

  // ****************************************************************
  // Filter identifier registers
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_FILTERS; i++) begin
        filtSid[i]               <= 11'h000;
        filtEid[i]               <= 18'h0_0000;
        filterFrameTypeSelect[i] <= 1'b0;
      end
    end else if (wrEn && inFilter) begin
      if (eidHalf) begin
        filtEid[filtIdx][15:0] <= pwdata[15:0];
      end else begin
        filtSid[filtIdx]               <= pwdata[15:`SIDREG_SID_LSB];
        filterFrameTypeSelect[filtIdx] <= pwdata[`SIDREG_TYPE_BIT];
        filtEid[filtIdx][17:16]        <= pwdata[1:`SIDREG_EIDHI_LSB];
      end
    end
  end

  // ****************************************************************
  // Mask registers
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int m = 0; m < NUM_MASKS; m++) begin
        maskSid[m]              <= 11'h000;
        maskEid[m]              <= 18'h0_0000;
        maskFrameTypeEnforce[m] <= 1'b0;
      end
    end else if (wrEn && inMask) begin
      if (eidHalf) begin
        maskEid[maskIdx][15:0] <= pwdata[15:0];
      end else begin
        maskSid[maskIdx]              <= pwdata[15:`SIDREG_SID_LSB];
        maskFrameTypeEnforce[maskIdx] <= pwdata[`SIDREG_TYPE_BIT];
        maskEid[maskIdx][17:16]       <= pwdata[1:`SIDREG_EIDHI_LSB];
      end
    end
  end

  // ****************************************************************
  // Match array
  // ****************************************************************
  logic [NUM_FILTERS-1:0] hitVec;

  generate
    for (genvar f = 0; f < NUM_FILTERS; f++) begin : gen_filter
      logic [1:0] sel;
      logic       selOk;
      assign sel   = filterMaskChoice[f];
      assign selOk = (sel != `MASKSEL_RESERVED);
      filter_match u_match (
        .enable    (filterAcceptEnable[f]),
        .filtSid   (filtSid[f]),
        .filtEid   (filtEid[f]),
        .filtType  (filterFrameTypeSelect[f]),
        .maskValid (selOk),
        .maskSid   (selOk ? maskSid[sel] : 11'h000),
        .maskEid   (selOk ? maskEid[sel] : 18'h0_0000),
        .maskType  (selOk ? maskFrameTypeEnforce[sel] : 1'b0),
        .msgSid    (msgSid),
        .msgEid    (msgEid),
        .msgExt    (msgExt),
        .hit       (hitVec[f])
      );
    end
  endgenerate

  // The lowest-numbered hitting filter takes the message.
  logic        anyHit;
  logic [3:0]  winner;

  always_comb begin
    anyHit = 1'b0;
    winner = 4'h0;
    for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
      if (hitVec[i]) begin
        anyHit = 1'b1;
        winner = 4'(i);
      end
    end
  end

  target_ptr_t winPtr;
  logic        winFifo;

  assign winPtr  = filterTargetPointer[winner];
  assign winFifo = (winPtr == `PTR_FIFO_CODE);

  // ****************************************************************
  // Steering output
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acceptValid  <= 1'b0;
      acceptFifo   <= 1'b0;
      acceptBuffer <= 4'h0;
      acceptFilter <= 4'h0;
    end else begin
      acceptValid <= msgValid & anyHit;
      if (msgValid && anyHit) begin
        acceptFifo   <= winFifo;
        acceptBuffer <= winPtr;
        acceptFilter <= winner;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lastFilter  <= 4'h0;
      lastPointer <= 4'h0;
      lastFifo    <= 1'b0;
      hitSeen     <= 1'b0;
    end else if (msgValid && anyHit) begin
      lastFilter  <= winner;
      lastPointer <= winPtr;
      lastFifo    <= winFifo;
      hitSeen     <= 1'b1;
    end
  end

  // ****************************************************************
  // Receive buffer full flags
  // ****************************************************************
  reg16_t setMask;
  reg16_t clrMask;

  assign setMask = (msgValid && anyHit && !winFifo) ? (16'h0001 << winPtr) : 16'h0000;
  assign clrMask = (wrEn && paddr == `OFF_RX_FULL) ? pwdata[15:0] : 16'h0000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxSlotFullFlag <= 16'h0000;
    end else begin
      rxSlotFullFlag <= (rxSlotFullFlag & ~clrMask) | setMask;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (inFilter) begin
      if (eidHalf) begin
        next_prdata[15:0] = filtEid[filtIdx][15:0];
      end else begin
        next_prdata[15:0] = {filtSid[filtIdx], 1'b0, filterFrameTypeSelect[filtIdx], 1'b0,
                             filtEid[filtIdx][17:16]};
      end
    end else if (inMask) begin
      if (eidHalf) begin
        next_prdata[15:0] = maskEid[maskIdx][15:0];
      end else begin
        next_prdata[15:0] = {maskSid[maskIdx], 1'b0, maskFrameTypeEnforce[maskIdx], 1'b0,
                             maskEid[maskIdx][17:16]};
      end
    end else begin
      case (paddr)
        `OFF_FILTER_ENABLE: begin
          next_prdata[15:0] = filterAcceptEnable;
        end
        `OFF_BUFPNT_0_3, `OFF_BUFPNT_4_7, `OFF_BUFPNT_8_11, `OFF_BUFPNT_12_15: begin
          // The first pointer word holds filters 0-3, each later word the next four.
          for (int k = 0; k < 4; k++) begin
            next_prdata[4 * k +: 4] = filterTargetPointer[4 * (int'(paddr[4:2]) - 1) + k];
          end
        end
        `OFF_MASKSEL_0_7, `OFF_MASKSEL_8_15: begin
          // The lower selection word holds filters 0-7, the upper one filters 8-15.
          for (int k = 0; k < 8; k++) begin
            next_prdata[2 * k +: 2] = filterMaskChoice[8 * int'(paddr[3]) + k];
          end
        end
        `OFF_RX_FULL: begin
          next_prdata[15:0] = rxSlotFullFlag;
        end
        `OFF_HIT_STATUS: begin
          next_prdata[9:0] = {hitSeen, lastFifo, lastPointer, lastFilter};
        end
        default: begin
          next_prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Read data is only driven while the access phase is open, so the bus
  // sees zero between transfers.
  assign prdata = rdEn ? next_prdata : 32'h0000_0000;

endmodule // can_acceptance_filter_steering

// ===== design/can_filter_map.svh
// What this block does
// - Lower pointer code selects that buffer index
// - Four 4-bit pointers per register, reset zero
// - Sixteen filters with 11-bit and 18-bit identifiers
// - Compared message bit must equal filter bit
// - Extended bits 15-0 held in own register
// - Two-bit mask choice, code 11 reserved
// - Mask selection fields packed two bits each
// - Unused identifier register bits read zero
// - Only mask-one positions take part in compare
// - Per-filter enable, set at reset
// - Buffer write sets full flag, software clears
`ifndef CAN_FILTER_MAP_SVH
`define CAN_FILTER_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFF_FILTER_ENABLE      8'h00
`define OFF_BUFPNT_0_3         8'h04
`define OFF_BUFPNT_4_7         8'h08
`define OFF_BUFPNT_8_11        8'h0C
`define OFF_BUFPNT_12_15       8'h10
`define OFF_MASKSEL_0_7        8'h14
`define OFF_MASKSEL_8_15       8'h18
`define OFF_RX_FULL            8'h20
`define OFF_HIT_STATUS         8'h24
`define OFF_FILTER_BASE        8'h40
`define OFF_FILTER_LAST        8'hBC
`define OFF_MASK_BASE          8'hC0
`define OFF_MASK_LAST          8'hD4

// ****************************************************************
// Field positions
// ****************************************************************
`define SIDREG_SID_LSB         5
`define SIDREG_TYPE_BIT        3
`define SIDREG_EIDHI_LSB       0
`define SIDREG_WRITE_MASK      16'hFFEB
`define PTR_FIFO_CODE          4'hF
`define MASKSEL_RESERVED       2'b11

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_FILTER_ENABLE      16'hFFFF
`define RST_BUFPNT             16'h0000
`define RST_MASKSEL            16'h0000
`define RST_IDENT              16'h0000

`endif

// ===== design/can_filter_pkg.sv
package can_filter_pkg;

  typedef logic [3:0]  target_ptr_t;
  typedef logic [1:0]  mask_choice_t;
  typedef logic [10:0] std_id_t;
  typedef logic [17:0] ext_id_t;
  typedef logic [15:0] reg16_t;

endpackage

// ===== design/filter_match.sv
`timescale 1ns/1ps
module filter_match
  import can_filter_pkg::*;
(
  // Filter pattern
  input  wire logic    enable,
  input  wire std_id_t filtSid,
  input  wire ext_id_t filtEid,
  input  wire logic    filtType,
  // Selected mask
  input  wire logic    maskValid,
  input  wire std_id_t maskSid,
  input  wire ext_id_t maskEid,
  input  wire logic    maskType,
  // Message under test
  input  wire std_id_t msgSid,
  input  wire ext_id_t msgEid,
  input  wire logic    msgExt,
  // Result
  output logic         hit
);
  import can_filter_pkg::*;

  logic sidOk;
  logic eidOk;
  logic typeOk;

  assign sidOk = ~|((msgSid ^ filtSid) & maskSid);
  assign eidOk = ~|((msgEid ^ filtEid) & maskEid) | ~msgExt;
  assign typeOk = ~maskType | (filtType == msgExt);
  assign hit = enable & maskValid & sidOk & eidOk & typeOk;

endmodule // filter_match

// ===== tb/can_filter_props.sv
`timescale 1ns/1ps
module can_filter_props
  import can_filter_pkg::*;
(
  // Clock and bus
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  // Message and steering
  input wire logic        msgValid,
  input wire logic        acceptValid,
  input wire logic        acceptFifo,
  input wire target_ptr_t acceptBuffer,
  input wire reg16_t      rxSlotFullFlag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence sRead;
    psel && penable && !pwrite;
  endsequence
  sequence sNoClear;
    !(psel && penable && pwrite && paddr == 8'h20);
  endsequence

  a_pulse_cause: assert property (!msgValid |=> !acceptValid)
    else $error("accept without message");
  a_fifo_code: assert property (acceptValid && acceptFifo |-> acceptBuffer == 4'hF)
    else $error("fifo accept with wrong code");
  a_fifo_noflag: assert property (rxSlotFullFlag[15] == 1'b0)
    else $error("fifo code set a full flag");
  a_buffer_code: assert property (acceptValid && !acceptFifo |-> acceptBuffer != 4'hF)
    else $error("buffer accept with fifo code");
  a_flag_set: assert property (acceptValid && !acceptFifo |-> rxSlotFullFlag[acceptBuffer])
    else $error("full flag not set");
  a_flag_sticky: assert property (sNoClear |=>
      (rxSlotFullFlag & $past(rxSlotFullFlag)) == $past(rxSlotFullFlag))
    else $error("full flag dropped without clear");
  a_read_upper: assert property (sRead |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_sid_unused: assert property (sRead and (paddr >= 8'h40 && paddr <= 8'hBC && !paddr[2])
      |-> {prdata[4], prdata[2]} == 2'b00)
    else $error("unused identifier bits not zero");
endmodule // can_filter_props

// ===== tb/can_bus_node.sv
`timescale 1ns/1ps
module can_bus_node
  import can_filter_pkg::*;
(
  input  wire logic clk,
  output logic      msgValid,
  output std_id_t   msgSid,
  output ext_id_t   msgEid,
  output logic      msgExt
);
  initial begin
    msgValid = 1'b0;
    msgSid   = 11'h000;
    msgEid   = 18'h0_0000;
    msgExt   = 1'b0;
  end

  // Identifiers turn to junk once the frame is over.
  task automatic send(input std_id_t s, input ext_id_t e, input logic x);
    @(posedge clk);
    msgValid <= 1'b1;
    msgSid   <= s;
    msgEid   <= e;
    msgExt   <= x;
    @(posedge clk);
    msgValid <= 1'b0;
    msgSid   <= ~s;
    msgEid   <= ~e;
    msgExt   <= ~x;
  endtask
endmodule // can_bus_node

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import can_filter_pkg::*;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, slvErr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdVal;
  logic msgValid, msgExt, acceptValid, acceptFifo;
  std_id_t msgSid;
  ext_id_t msgEid;
  target_ptr_t acceptBuffer;
  logic [3:0] acceptFilter;
  reg16_t rxSlotFullFlag;
  int errorCnt = 0;
  int checks = 0;

  can_acceptance_filter_steering DUT (.clk, .reset_n, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .msgValid, .msgSid, .msgEid, .msgExt,
    .acceptValid, .acceptFifo, .acceptBuffer, .acceptFilter, .rxSlotFullFlag);
  can_bus_node node (.clk, .msgValid, .msgSid, .msgEid, .msgExt);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic finishTest();
    if (errorCnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only pready or the watchdog ends a wait for the slave's answer.
    do @(posedge clk); while (pready !== 1'b1);
    rdVal = prdata;
    slvErr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0000_0000);
    chk("prdata", rdVal, exp);
  endtask

  task automatic sendChk(input std_id_t s, input ext_id_t e, input logic x,
                         input logic hit, input logic [3:0] f);
    node.send(s, e, x);
    #1;
    chk("acceptValid", acceptValid, hit);
    if (hit) chk("acceptFilter", acceptFilter, f);
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'h00, 32'h0000_FFFF);
    rd(8'h08, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    rd(8'h1C, 32'h0000_0000);
    chk("pslverr", slvErr, 32'h1);
    wr(8'h08, 32'h0000_6543);
    wr(8'h0C, 32'h0000_A987);
    wr(8'h10, 32'h0000_FDCB);
    rd(8'h10, 32'h0000_FDCB);
    rd(8'h04, 32'h0000_0000);
    rd(8'h0C, 32'h0000_A987);
    for (int f = 4; f < 16; f++) begin
      wr(8'h00, 32'h1 << f);
      sendChk(11'h000, 18'h0_0000, 1'b0, 1'b1, f[3:0]);
      chk("acceptFifo", acceptFifo, f == 15);
      chk("acceptBuffer", acceptBuffer, (f == 15) ? 4'hF : 4'(f - 1));
      chk("fullFlag", rxSlotFullFlag[f - 1], f != 15);
    end
    wr(8'h00, 32'h0000_0000);
    sendChk(11'h000, 18'h0_0000, 1'b0, 1'b0, 4'h0);
    wr(8'h20, 32'h0000_FFFF);
    rd(8'h20, 32'h0000_0000);
    wr(8'hC0, 32'h0000_FFEB);
    wr(8'hC4, 32'h0000_FFFF);
    wr(8'h40, 32'h0000_FFFF);
    rd(8'h40, 32'h0000_FFEB);
    wr(8'h40, 32'h0000_246A);
    wr(8'h44, 32'h0000_5A5A);
    wr(8'h00, 32'h0000_0001);
    sendChk(11'h123, 18'h2_5A5A, 1'b1, 1'b1, 4'h0);
    sendChk(11'h122, 18'h2_5A5A, 1'b1, 1'b0, 4'h0);
    sendChk(11'h123, 18'h2_5A5B, 1'b1, 1'b0, 4'h0);
    sendChk(11'h123, 18'h0_5A5A, 1'b1, 1'b0, 4'h0);
    sendChk(11'h123, 18'h2_5A5A, 1'b0, 1'b0, 4'h0);
    wr(8'hC4, 32'h0000_FFFE);
    sendChk(11'h123, 18'h2_5A5B, 1'b1, 1'b1, 4'h0);
    wr(8'h14, 32'h0000_0001);
    sendChk(11'h7FF, 18'h0_0000, 1'b0, 1'b1, 4'h0);
    wr(8'h14, 32'h0000_0003);
    sendChk(11'h7FF, 18'h0_0000, 1'b0, 1'b0, 4'h0);
    wr(8'h00, 32'h0000_0080);
    wr(8'h14, 32'h0000_8000);
    rd(8'h14, 32'h0000_8000);
    rd(8'h18, 32'h0000_0000);
    sendChk(11'h7FF, 18'h0_0000, 1'b0, 1'b1, 4'h7);
    rd(8'h24, 32'h0000_0267);
    finishTest();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    finishTest();
  end
endmodule // tb_top

bind can_acceptance_filter_steering can_filter_props u_props (.clk, .reset_n, .paddr,
  .psel, .penable, .pwrite, .prdata, .msgValid, .acceptValid, .acceptFifo,
  .acceptBuffer, .rxSlotFullFlag);
